// [logic/tccp_channel.sv]
`timescale 1ns/1ns
`default_nettype none
module tccp_channel (
  input wire logic clock,
  input wire logic rst_n,
  input wire tccp_pkg::tccp_mode_t mode,
  input wire logic [15:0] timer_value,
  input wire logic step,
  input wire logic overflow,
  input wire logic latch,
  input wire logic pin_in,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value,
  output logic pin_out,
  output logic pin_oe,
  output logic event_pulse
);

  tccp_pkg::tccp_chan_state_t st;
  tccp_pkg::tccp_chan_state_t next_st;
  logic match;

  // compare is only judged in the cycle after the timer moved, so a
  // stopped timer sitting on the compare value flags just once
  assign match = step && (timer_value == st.value);

  always_comb
  begin
    next_st = st;
    next_st.flag = 1'b0;
    next_st.pin_prev = pin_in;
    if (wr_en)
    begin
      next_st.value = wr_data;
    end
    unique case (mode)
      tccp_pkg::TCCP_OFF:
      begin
        next_st.pin = latch;
      end
      tccp_pkg::TCCP_CAPTURE:
      begin
        next_st.pin = latch;
        if (pin_in && !st.pin_prev)
        begin
          next_st.value = timer_value; // capture beats a same-cycle write
          next_st.flag = 1'b1;
        end
      end
      // high on match, low on overflow
      tccp_pkg::TCCP_CMP0:
      begin
        if (step && overflow)
        begin
          next_st.pin = 1'b0;
        end
        if (match)
        begin
          next_st.pin = 1'b1;
          next_st.flag = 1'b1;
        end
      end
      tccp_pkg::TCCP_CMP1:
      begin
        if (match)
        begin
          next_st.pin = latch;
          next_st.flag = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // a capture input is released so the outside circuit can drive it
  assign value = st.value;
  assign pin_out = st.pin;
  assign pin_oe = (mode != tccp_pkg::TCCP_CAPTURE);
  assign event_pulse = st.flag;

endmodule : tccp_channel
`default_nettype wire

// [logic/tccp_defines.svh]
`ifndef TCCP_DEFINES_SVH
`define TCCP_DEFINES_SVH

// register byte offsets
`define TCCP_OFS_CTRL 8'h00
`define TCCP_OFS_MODE 8'h04
`define TCCP_OFS_STATUS 8'h08
`define TCCP_OFS_MAIN_TIMER 8'h0C
`define TCCP_OFS_LATCH 8'h10
`define TCCP_OFS_PWM_CTRL 8'h14
`define TCCP_OFS_PWM_RELOAD 8'h18
`define TCCP_OFS_PWM_TIMER 8'h1C
`define TCCP_OFS_CH_BASE 8'h20
`define TCCP_OFS_CM_BASE 8'h40

// field positions
`define TCCP_CTRL_PSEL_LSB 0
`define TCCP_CTRL_RUN_BIT 2
`define TCCP_CTRL_RELOAD_BIT 3
`define TCCP_PWM_PSEL_LSB 0
`define TCCP_PWM_RUN_BIT 3

// reset values
`define TCCP_MAIN_PSEL_RESET 2'h0
`define TCCP_MAIN_RUN_RESET 1'b1
`define TCCP_PWM_PSEL_RESET 3'h0
`define TCCP_PWM_RUN_RESET 1'b1
`define TCCP_PWM_RELOAD_RESET 16'h0000

// counts
`define TCCP_NUM_CH 5
`define TCCP_NUM_CM 8
`define TCCP_MAIN_DIV 7'h0C
`define TCCP_PWM_DIV 8'h02
`define TCCP_PWM_PSEL_MAX 3'h6
`define TCCP_TIMER_TOP 16'hFFFF

`endif

// [logic/tccp_pkg.sv]
`default_nettype none
package tccp_pkg;

  // channel function select, two bits per channel
  typedef enum logic [1:0] {
    TCCP_OFF = 2'b00,
    TCCP_CAPTURE = 2'b01,
    TCCP_CMP0 = 2'b10,
    TCCP_CMP1 = 2'b11
  } tccp_mode_t;

  typedef struct packed {
    logic [15:0] value;
    logic pin;
    logic pin_prev;
    logic flag;
  } tccp_chan_state_t;

  typedef struct packed {
    logic [15:0] shadow;
    logic [15:0] active;
    logic pin;
  } tccp_cm_state_t;

  typedef struct packed {
    logic [15:0] main_timer;
    logic [6:0] main_pre;
    logic main_step;
    logic main_ovf;
    logic [1:0] main_psel;
    logic main_run;
    logic reload_en;
    logic [9:0] ch_mode;
    logic [5:0] status;
    logic [4:0] latch;
    logic [15:0] pwm_timer;
    logic [7:0] pwm_pre;
    logic pwm_step;
    logic pwm_ovf;
    logic [2:0] pwm_psel;
    logic pwm_run;
    logic [15:0] pwm_reload;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } tccp_state_t;

endpackage : tccp_pkg
`default_nettype wire

// [logic/tccp_shadow_cmp.sv]
`timescale 1ns/1ns
`default_nettype none
module tccp_shadow_cmp (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] timer_value,
  input wire logic step,
  input wire logic overflow,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] shadow,
  output logic pin_out
);

  tccp_pkg::tccp_cm_state_t st;
  tccp_pkg::tccp_cm_state_t next_st;

  // no flag output exists: buffering makes a mid-period rewrite harmless
  // no compare flag
  always_comb
  begin
    next_st = st;
    if (wr_en)
    begin
      next_st.shadow = wr_data;
    end
    if (step && overflow)
    begin
      next_st.active = wr_en ? wr_data : st.shadow;
      next_st.pin = 1'b0;
    end
    if (step && (timer_value == next_st.active))
    begin
      next_st.pin = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign shadow = st.shadow;
  assign pin_out = st.pin;

endmodule : tccp_shadow_cmp
`default_nettype wire

// [logic/tccp_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tccp_defines.svh"
module tccp_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [4:0] cc_pin_in,
  output logic [4:0] cc_pin_out,
  output logic [4:0] cc_pin_oe,
  output logic [7:0] pwm_out
);

  tccp_pkg::tccp_state_t st;
  tccp_pkg::tccp_state_t next_st;

  logic [15:0] ch_value [`TCCP_NUM_CH];
  logic [4:0] ch_event;
  logic [4:0] ch_wr;
  logic [15:0] cm_shadow [`TCCP_NUM_CM];
  logic [7:0] cm_wr;
  logic addr_take;
  logic [7:0] aa;
  logic [7:0] main_limit;
  logic [7:0] pwm_limit;
  logic [2:0] pwm_sel;
  logic main_tick;
  logic pwm_tick;

  // address phase is taken only when the bus really hands it to us
  assign addr_take = hsel && htrans[1] && hready;
  assign aa = haddr[7:0];

  assign main_limit = 8'((8'(`TCCP_MAIN_DIV) << st.main_psel) - 8'h01);
  assign main_tick = st.main_run && ({1'b0, st.main_pre} >= main_limit);

  // prescale 2 up to 128
  // codes above the top divider clamp to it rather than wrap to a fast rate
  assign pwm_sel = (st.pwm_psel > `TCCP_PWM_PSEL_MAX) ? `TCCP_PWM_PSEL_MAX : st.pwm_psel;
  assign pwm_limit = 8'((`TCCP_PWM_DIV << pwm_sel) - 8'h01);
  assign pwm_tick = st.pwm_run && (st.pwm_pre >= pwm_limit);

  genvar gi;
  generate
    for (gi = 0; gi < `TCCP_NUM_CH; gi++)
    begin : g_ch
      localparam logic [7:0] CH_ADDR = 8'(`TCCP_OFS_CH_BASE + 4 * gi);
      assign ch_wr[gi] = st.wr_pend && (st.wr_addr == CH_ADDR);
      tccp_channel u_ch (
        .clock(clock),
        .rst_n(rst_n),
        .mode(tccp_pkg::tccp_mode_t'(st.ch_mode[2 * gi +: 2])),
        .timer_value(st.main_timer),
        .step(st.main_step),
        .overflow(st.main_ovf),
        .latch(st.latch[gi]),
        .pin_in(cc_pin_in[gi]),
        .wr_en(ch_wr[gi]),
        .wr_data(hwdata[15:0]),
        .value(ch_value[gi]),
        .pin_out(cc_pin_out[gi]),
        .pin_oe(cc_pin_oe[gi]),
        .event_pulse(ch_event[gi])
      );
    end
  endgenerate

  generate
    for (gi = 0; gi < `TCCP_NUM_CM; gi++)
    begin : g_cm
      localparam logic [7:0] CM_ADDR = 8'(`TCCP_OFS_CM_BASE + 4 * gi);
      assign cm_wr[gi] = st.wr_pend && (st.wr_addr == CM_ADDR);
      tccp_shadow_cmp u_cm (
        .clock(clock),
        .rst_n(rst_n),
        .timer_value(st.pwm_timer),
        .step(st.pwm_step),
        .overflow(st.pwm_ovf),
        .wr_en(cm_wr[gi]),
        .wr_data(hwdata[15:0]),
        .shadow(cm_shadow[gi]),
        .pin_out(pwm_out[gi])
      );
    end
  endgenerate

  // next state: timers, register writes, flags and read capture
  always_comb
  begin
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic [7:0] idx;
    next_st = st;
    flag_set = 6'h00;
    flag_clr = 6'h00;
    idx = 8'h00;
    next_st.main_step = 1'b0;
    next_st.main_ovf = 1'b0;
    next_st.pwm_step = 1'b0;
    next_st.pwm_ovf = 1'b0;

    // main prescaler and counter
    if (st.main_run)
    begin
      next_st.main_pre = main_tick ? 7'h00 : 7'(st.main_pre + 7'h01);
    end
    if (main_tick)
    begin
      next_st.main_step = 1'b1;
      if (st.main_timer == `TCCP_TIMER_TOP)
      begin
        next_st.main_ovf = 1'b1;
        next_st.main_timer = st.reload_en ? ch_value[0] : 16'h0000;
      end
      else
      begin
        next_st.main_timer = 16'(st.main_timer + 16'h0001);
      end
    end

    // PWM prescaler and counter
    if (st.pwm_run)
    begin
      next_st.pwm_pre = pwm_tick ? 8'h00 : 8'(st.pwm_pre + 8'h01);
    end
    if (pwm_tick)
    begin
      next_st.pwm_step = 1'b1;
      if (st.pwm_timer == `TCCP_TIMER_TOP)
      begin
        next_st.pwm_ovf = 1'b1;
        next_st.pwm_timer = st.pwm_reload;
      end
      else
      begin
        next_st.pwm_timer = 16'(st.pwm_timer + 16'h0001);
      end
    end

    flag_set[0] = st.main_step && st.main_ovf;
    flag_set[5:1] = ch_event;

    // data phase of a write; a timer write overrides the count this cycle
    if (st.wr_pend)
    begin
      unique case (st.wr_addr)
        `TCCP_OFS_CTRL:
        begin
          next_st.main_psel = hwdata[`TCCP_CTRL_PSEL_LSB +: 2];
          next_st.main_run = hwdata[`TCCP_CTRL_RUN_BIT];
          next_st.reload_en = hwdata[`TCCP_CTRL_RELOAD_BIT];
        end
        `TCCP_OFS_MODE:
        begin
          next_st.ch_mode = hwdata[9:0];
        end
        `TCCP_OFS_STATUS:
        begin
          flag_clr = hwdata[5:0];
        end
        `TCCP_OFS_MAIN_TIMER:
        begin
          next_st.main_timer = hwdata[15:0];
        end
        `TCCP_OFS_LATCH:
        begin
          next_st.latch = hwdata[4:0];
        end
        `TCCP_OFS_PWM_CTRL:
        begin
          next_st.pwm_psel = hwdata[`TCCP_PWM_PSEL_LSB +: 3];
          next_st.pwm_run = hwdata[`TCCP_PWM_RUN_BIT];
        end
        `TCCP_OFS_PWM_RELOAD:
        begin
          next_st.pwm_reload = hwdata[15:0];
        end
        `TCCP_OFS_PWM_TIMER:
        begin
          next_st.pwm_timer = hwdata[15:0];
        end
        default:
        begin
          next_st.ch_mode = st.ch_mode; // channel, shadow or unmapped
        end
      endcase
    end

    next_st.status = (st.status & ~flag_clr) | flag_set;

    // address phase bookkeeping
    next_st.wr_pend = addr_take && hwrite;
    next_st.wr_addr = aa;

    // read data is captured in the address phase so hrdata is a flop;
    // a read right behind a write to the same word sees the old value
    if (addr_take && !hwrite)
    begin
      next_st.rdata = 32'h0000_0000;
      unique case (aa)
        `TCCP_OFS_CTRL:
        begin
          next_st.rdata[`TCCP_CTRL_PSEL_LSB +: 2] = st.main_psel;
          next_st.rdata[`TCCP_CTRL_RUN_BIT] = st.main_run;
          next_st.rdata[`TCCP_CTRL_RELOAD_BIT] = st.reload_en;
        end
        `TCCP_OFS_MODE:
        begin
          next_st.rdata[9:0] = st.ch_mode;
        end
        `TCCP_OFS_STATUS:
        begin
          next_st.rdata[5:0] = st.status;
        end
        `TCCP_OFS_MAIN_TIMER:
        begin
          next_st.rdata[15:0] = st.main_timer;
        end
        `TCCP_OFS_LATCH:
        begin
          next_st.rdata[4:0] = st.latch;
        end
        `TCCP_OFS_PWM_CTRL:
        begin
          next_st.rdata[`TCCP_PWM_PSEL_LSB +: 3] = st.pwm_psel;
          next_st.rdata[`TCCP_PWM_RUN_BIT] = st.pwm_run;
        end
        `TCCP_OFS_PWM_RELOAD:
        begin
          next_st.rdata[15:0] = st.pwm_reload;
        end
        `TCCP_OFS_PWM_TIMER:
        begin
          next_st.rdata[15:0] = st.pwm_timer;
        end
        default:
        begin
          // channel and shadow words; the active comparators have no address
          if (aa >= `TCCP_OFS_CH_BASE && aa < 8'(`TCCP_OFS_CH_BASE + 4 * `TCCP_NUM_CH) && aa[1:0] == 2'h0)
          begin
            idx = 8'((aa - `TCCP_OFS_CH_BASE) >> 2);
            next_st.rdata[15:0] = ch_value[idx[2:0]];
          end
          else if (aa >= `TCCP_OFS_CM_BASE && aa < 8'(`TCCP_OFS_CM_BASE + 4 * `TCCP_NUM_CM) && aa[1:0] == 2'h0)
          begin
            idx = 8'((aa - `TCCP_OFS_CM_BASE) >> 2);
            next_st.rdata[15:0] = cm_shadow[idx[2:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.main_psel <= `TCCP_MAIN_PSEL_RESET;
      st.main_run <= `TCCP_MAIN_RUN_RESET;
      st.pwm_psel <= `TCCP_PWM_PSEL_RESET;
      st.pwm_run <= `TCCP_PWM_RUN_RESET;
      st.pwm_reload <= `TCCP_PWM_RELOAD_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // zero wait states and always OKAY; hsize is accepted but only words mean anything
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

endmodule : tccp_top
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [4:0] cc_pin_in;
  logic [4:0] cc_pin_out;
  logic [4:0] cc_pin_oe;
  logic [7:0] pwm_out;
  int mismatches;
  int samples_checked;
  int cycles;
  int hi;
  int e;
  logic [31:0] rd;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h40, 8'h60};
  logic [31:0] re [9] = '{32'h4, 32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
  // one slave, so its ready is the bus ready
  assign hready = hreadyout;
  tccp_top dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .pwm_out(pwm_out));
  // 125 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one single AHB transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rdat = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h0, rd);
  endtask : rdr
  task automatic in_range(input logic [31:0] lo, input logic [31:0] up);
    check({31'h0, rd >= lo && rd <= up}, 32'h1);
  endtask : in_range
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cc_pin_in = 5'h00;
    mismatches = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    hsel <= 1'b1;
    @(posedge clock);
    wr(8'h60, 32'hFFFFFFFF);
    foreach (ra[i])
    begin
      rdr(ra[i]);
      check(rd, re[i]);
    end
    $display("test reset_values done");
    wr(8'h08, 32'h3F);
    wr(8'h0C, 32'hFFFE);
    repeat (40) @(posedge clock);
    rdr(8'h08);
    check(rd, 32'h1);
    wr(8'h08, 32'h1);
    rdr(8'h08);
    check(rd, 32'h0);
    $display("test overflow_flag done");
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h1234);
    wr(8'h04, 32'h10);
    cc_pin_in <= 5'h04;
    repeat (4) @(posedge clock);
    cc_pin_in <= 5'h00;
    rdr(8'h28);
    check(rd, 32'h1234);
    rdr(8'h08);
    check(rd, 32'h8);
    $display("test capture done");
    wr(8'h08, 32'h3F);
    wr(8'h24, 32'h10);
    wr(8'h2C, 32'h10);
    wr(8'h04, 32'hC8);
    wr(8'h10, 32'h08);
    repeat (3) @(posedge clock);
    check({31'h0, cc_pin_out[3]}, 32'h0);
    wr(8'h0C, 32'h8);
    wr(8'h00, 32'h4);
    repeat (150) @(posedge clock);
    check({27'h0, cc_pin_out & 5'h0A}, 32'h0A);
    rdr(8'h08);
    check(rd, 32'h14);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'hFFF0);
    repeat (280) @(posedge clock);
    check({27'h0, cc_pin_out & 5'h0A}, 32'h08);
    $display("test compare_modes done");
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h1234);
    wr(8'h0C, 32'hFFFF);
    wr(8'h00, 32'hC);
    repeat (20) @(posedge clock);
    rdr(8'h0C);
    in_range(32'h1234, 32'h1236);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h00, 32'h4 | p);
      wr(8'h0C, 32'h0);
      repeat (240) @(posedge clock);
      rdr(8'h0C);
      e = 240 / (12 << p);
      in_range(e - 1, e + 2);
    end
    wr(8'h00, 32'h0);
    $display("test main_rates done");
    wr(8'h08, 32'h3F);
    wr(8'h18, 32'hFFF0);
    wr(8'h40, 32'hFFF8);
    rdr(8'h40);
    check(rd, 32'hFFF8);
    for (int p = 0; p < 2; p++)
    begin
      wr(8'h14, 32'h8 | p);
      wr(8'h1C, 32'hFFF0);
      repeat (64 << p) @(posedge clock);
      hi = 0;
      repeat (320 << p)
      begin
        @(posedge clock);
        if (pwm_out[0] === 1'b1)
          hi++;
      end
      rd = hi;
      in_range((160 << p) - (12 << p), (160 << p) + (12 << p));
    end
    rdr(8'h08);
    check(rd, 32'h0);
    $display("test pwm_timer done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// [testbench/tccp_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module tccp_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [4:0] cc_pin_out,
  input wire logic [4:0] cc_pin_oe,
  input wire logic [7:0] pwm_out
);
  logic ap_wr;
  logic [7:0] ap_addr;
  logic [9:0] mode_q;
  logic [4:0] latch_q;
  logic [4:0] off_m;
  logic [4:0] cap_m;
  logic [4:0] c1_m;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // snoop mode and latch writes, since the checker cannot see the registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      mode_q <= 10'h000;
      latch_q <= 5'h00;
    end
    else
    begin
      ap_wr <= hsel && htrans[1] && hready && hwrite;
      ap_addr <= haddr[7:0];
      if (ap_wr && ap_addr == 8'h04)
        mode_q <= hwdata[9:0];
      if (ap_wr && ap_addr == 8'h10)
        latch_q <= hwdata[4:0];
    end
  end
  // per-channel masks decoded from the snooped mode field
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      off_m[i] = mode_q[2*i +: 2] == 2'b00;
      cap_m[i] = mode_q[2*i +: 2] == 2'b01;
      c1_m[i] = mode_q[2*i +: 2] == 2'b11;
    end
  end
  ready_always_a: assert property (hreadyout == 1'b1) // bus contract
    else $error("hreadyout went low");
  resp_okay_a: assert property (hresp == 1'b0) // bus contract
    else $error("hresp not okay");
  rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata)) // bus contract
    else $error("hrdata changed without a read");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  reset_pins_a: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n |=> cc_pin_out == 5'h00 && pwm_out == 8'h00 && cc_pin_oe == 5'h1F && hrdata == 32'h0)
    else $error("outputs not at reset level");
  oe_mode_a: assert property ($stable(mode_q) |-> cc_pin_oe == ~cap_m)
    else $error("pin enable disagrees with mode");
  off_latch_a: assert property ($stable(mode_q) && $stable(latch_q)
    |-> (cc_pin_out & off_m) == (latch_q & off_m))
    else $error("idle channel pin not following latch");
  cmp1_latch_a: assert property ($stable(mode_q) && $stable(latch_q)
    |-> ((cc_pin_out ^ $past(cc_pin_out)) & (cc_pin_out ^ latch_q) & c1_m) == 5'h00)
    else $error("mode 1 pin took a value other than latch");
  cmp0_rise_c: cover property ($rose(cc_pin_out[1]));
  capture_c: cover property ($fell(cc_pin_oe[2]));
  pwm_rise_c: cover property ($rose(pwm_out[0]));
endmodule : tccp_chk
bind tccp_top tccp_chk u_chk (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .pwm_out(pwm_out));
`default_nettype wire
